// [bench/ir_link_peer.sv]
// Purpose: far-side transceiver driving the receive pin
// Assumes: bit time and pulse width in core clocks
// Notes: infrared receiver output is active low, idles high
`timescale 1ns/100ps
module ir_link_peer #(
    parameter int BIT_CYC = 80,
    parameter int PULSE   = 15
) (
    input  wire logic core_clk,
    output logic      rxd
);
    initial rxd = 1'b1;
    // one character: start, data lsb first, even parity (flip breaks it), stop
    task automatic send(input logic [7:0] d, input logic ir, input logic flip);
        logic [10:0] f;
        f = {1'b1, (^d) ^ flip, d, 1'b0};
        for (int i = 0; i < 11; i++)
            for (int c = 0; c < BIT_CYC; c++)
            begin
                @(posedge core_clk);
                rxd <= ir ? !(!f[i] && c < PULSE) : f[i];
            end
        @(posedge core_clk);
        rxd <= 1'b1;
    endtask : send
    // a lone short low pulse, as from ambient light
    task automatic blip();
        @(posedge core_clk);
        rxd <= 1'b0;
        repeat (PULSE) @(posedge core_clk);
        rxd <= 1'b1;
    endtask : blip
endmodule : ir_link_peer

// [bench/usart_irda_rs485_modes_test.sv]
// Purpose: register-level test of line-driver, T=1 and infrared modes
// Assumes: divisor 5, so one bit is 80 core clocks
// Notes: expected frames are built here from the character
`timescale 1ns/100ps
module usart_irda_rs485_modes_test;
    import uart_modes_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, rxd, txd, rts, irq;
    logic [10:0] fr;
    int          failures = 0;
    int          check_count = 0;
    int          n, p;
    always #50 core_clk = ~core_clk;
    uart_line_modes u_dut (.core_clk(core_clk), .resetn(resetn),
        .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd),
        .rts(rts), .irq(irq));
    ir_link_peer u_peer (.core_clk(core_clk), .rxd(rxd));
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) failures++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd
    // sample txd at the middle of each bit after a start edge
    task automatic cap();
        for (int k = 0; k < 200 && txd !== 1'b0; k++) @(posedge core_clk);
        repeat (40) @(posedge core_clk);
        for (int i = 0; i < 11; i++)
        begin
            fr[i] = txd;
            repeat (80) @(posedge core_clk);
        end
    endtask : cap
    // count light cycles and pulses on txd over a span of clocks
    task automatic count_light(input int span);
        logic prv;
        prv = 1'b0;
        n = 0;
        p = 0;
        repeat (span)
        begin
            @(posedge core_clk);
            n += (txd === 1'b1);
            p += (txd === 1'b1 && prv !== 1'b1);
            prv = txd;
        end
    endtask : count_light
    task automatic results();
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // watchdog
    initial
    begin
        #3_000_000;
        failures++;
        results();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(ADDR_RATIO, 32'h174, "ratio_reset");
        rd(6'h3C, 32'h0, "unmapped");
        bus(1'b1, ADDR_RATIO, 32'h174);
        bus(1'b1, ADDR_DIV, 32'h5);
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b1, ADDR_MODE, 32'h201);
        bus(1'b1, ADDR_TXDATA, 32'h55);
        n = 0;
        repeat (1100) @(posedge core_clk) n += (rts === 1'b1);
        // twelve bit times; start bit may lose up to four clocks to tick phase
        chk("rts_span", 1, n >= 955 && n <= 960);
        rd(ADDR_STATUS, 32'h108, "all_done");
        bus(1'b1, ADDR_MODE, 32'h25);
        bus(1'b1, ADDR_TXDATA, 32'h07);
        cap();
        chk("t1_frame", {1'b1, 1'b1, 8'h07, 1'b0}, fr);
        bus(1'b1, ADDR_CTRL, 32'h2);
        bus(1'b1, ADDR_MASK, 32'h2);
        bus(1'b1, ADDR_STATUS, 32'hF);
        u_peer.send(8'h81, 1'b0, 1'b0);
        rd(ADDR_RXDATA, 32'h81, "t1_rx");
        rd(ADDR_STATUS, 32'h1, "t1_good");
        u_peer.send(8'h3C, 1'b0, 1'b1);
        chk("irq_set", 1, irq);
        rd(ADDR_STATUS, 32'h3, "t1_bad");
        bus(1'b1, ADDR_STATUS, 32'h2);
        repeat (2) @(posedge core_clk);
        chk("irq_clr", 0, irq);
        // infrared with even parity on, matching the far side's frame
        bus(1'b1, ADDR_MODE, 32'h18);
        bus(1'b1, ADDR_FILT, 32'h2);
        bus(1'b1, ADDR_STATUS, 32'hF);
        u_peer.send(8'h5A, 1'b1, 1'b0);
        rd(ADDR_RXDATA, 32'h5A, "ir_rx");
        bus(1'b1, ADDR_STATUS, 32'hF);
        bus(1'b1, ADDR_FILT, 32'hFF);
        u_peer.blip();
        repeat (1000) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h0, "ir_glitch");
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b1, ADDR_TXDATA, 32'h0F);
        count_light(1100);
        // start, four zero data bits, zero parity: 15 clocks each,
        // the start pulse may lose up to four clocks to tick phase
        chk("ir_light", 1, n >= 86 && n <= 90);
        chk("ir_pulses", 6, p);
        bus(1'b1, ADDR_DIV, 32'h1);
        bus(1'b1, ADDR_TXDATA, 32'h00);
        count_light(200);
        chk("ir_fast_light", 30, n);
        chk("ir_fast_pulses", 10, p);
        results();
    end
endmodule : usart_irda_rs485_modes_test

// [include/uart_modes_pkg.sv]
// Purpose: constants, types and helpers for the serial line-mode block
// Assumes: one core clock at 10 MHz, 16 sub-ticks per bit
// Notes: register offsets are byte addresses of 32-bit words
// Summary of operation
// - smart-card T=1 frames use one stop bit
// - T=1 generates, checks parity, flags errors
// - mode 0x8 selects infrared, modem in path
// - infrared works from 2.4 to 115.2 kb/s
// - infrared zero bit is 3/16 bit pulse
// - receive filter is preloaded 8-bit down counter
// - falling edge starts decrement every clock
// - rising edge stops count and reloads value
// - count reaching zero drives receiver low one bit
// - mode 0x1 selects line-driver mode
// - line-driver mode keeps normal serial behaviour
// - line driver enable is inverse of transmitter done
// - enable stays high through trailing timeguard
// - mode 0x5 selects smart-card T=1
// - smart-card format fixed eight bits even parity
package uart_modes_pkg;
    localparam logic [5:0] ADDR_CTRL   = 6'h00;
    localparam logic [5:0] ADDR_MODE   = 6'h04;
    localparam logic [5:0] ADDR_DIV    = 6'h08;
    localparam logic [5:0] ADDR_FILT   = 6'h0C;
    localparam logic [5:0] ADDR_RATIO  = 6'h10;
    localparam logic [5:0] ADDR_TXDATA = 6'h14;
    localparam logic [5:0] ADDR_RXDATA = 6'h18;
    localparam logic [5:0] ADDR_STATUS = 6'h1C;
    localparam logic [5:0] ADDR_MASK   = 6'h20;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_RS485  = 4'h1;
    localparam logic [3:0] MODE_T1     = 4'h5;
    localparam logic [3:0] MODE_IRDA   = 4'h8;
    localparam int CTRL_TXEN = 0;
    localparam int CTRL_RXEN = 1;
    localparam int ST_RXRDY = 0;
    localparam int ST_PARITY_ERROR_FLAG  = 1;
    localparam int ST_FRAME = 2;
    localparam int ST_TXDONE = 3;
    localparam int ST_ALLDONE = 8;
    localparam int EV_W = 4;
    localparam logic [15:0] DIV_RESET   = 16'h0000;
    localparam logic [7:0]  FILT_RESET  = 8'h00;
    localparam logic [10:0] RATIO_RESET = 11'h174;
    localparam logic [3:0] SUB_LAST   = 4'hF;
    localparam logic [3:0] SUB_MID    = 4'h7;
    localparam logic [3:0] IR_PULSE   = 4'h3;
    localparam logic [2:0] DATA_LAST  = 3'h7;
    localparam int CLK_HZ      = 10_000_000;
    localparam int SUBS_PER_BIT = 16;
    localparam int IR_MIN_BPS  = 2_400;
    localparam int IR_MAX_BPS  = 115_200;
    localparam int CD_SLOWEST  = CLK_HZ / (SUBS_PER_BIT * IR_MIN_BPS);
    localparam int CD_FASTEST  = CLK_HZ / (SUBS_PER_BIT * IR_MAX_BPS);

    typedef struct packed {
        logic [7:0] guard;
        logic [1:0] pad;
        logic       par_odd;
        logic       par_en;
        logic [3:0] mode;
    } mode_cfg_s;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'b000001,
        TX_START = 6'b000010,
        TX_DATA  = 6'b000100,
        TX_PAR   = 6'b001000,
        TX_STOP  = 6'b010000,
        TX_GUARD = 6'b100000
    } tx_state_e;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_PAR   = 5'b01000,
        RX_STOP  = 5'b10000
    } rx_state_e;

    // parity bit for a character, even or odd
    function automatic logic parity_of(input logic [7:0] d,
                                       input logic odd);
        parity_of = (^d) ^ odd;
    endfunction : parity_of
endpackage : uart_modes_pkg

// [logic/irda_rx_filter.sv]
// Purpose: infrared receive demodulator with glitch filter
// Assumes: line_in already synchronised to core_clk
// Notes: line_out idles high; low pulse lasts one bit time
`timescale 1ns/100ps
module irda_rx_filter
    import uart_modes_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       active,
    input  wire logic       line_in,
    input  wire logic [7:0] filter_value,
    input  wire logic       tick,
    output logic            line_out
);
    logic       prev_ff;
    logic       counting_ff;
    logic [7:0] cnt_ff;
    logic       low_ff;
    logic [3:0] low_sub_ff;
    wire        fall = prev_ff & ~line_in;
    wire        rise = ~prev_ff & line_in;
    wire        expire = counting_ff & ~rise & (cnt_ff == 8'h00);
    wire        low_end = low_ff & tick & (low_sub_ff == SUB_LAST);

    // edge tracking
    always_ff @(posedge core_clk)
        if (!resetn) prev_ff <= 1'b1;
        else if (clk_en) prev_ff <= line_in;

    // preloaded down counter
    always_ff @(posedge core_clk)
    begin
        if (!resetn || (clk_en && !active))
        begin
            counting_ff <= 1'b0;
            cnt_ff      <= 8'h00;
        end
        else if (clk_en)
        begin
            if (counting_ff && rise)
            begin
                counting_ff <= 1'b0;
                cnt_ff      <= filter_value;
            end
            else if (expire)
            begin
                counting_ff <= 1'b0;
                cnt_ff      <= filter_value;
            end
            else if (counting_ff)
                cnt_ff <= cnt_ff - 8'h01;
            else if (fall)
            begin
                counting_ff <= 1'b1;
                cnt_ff      <= filter_value;
            end
            else
                cnt_ff <= filter_value;
        end
    end

    // one-bit low output after a surviving pulse
    always_ff @(posedge core_clk)
    begin
        if (!resetn || (clk_en && !active))
        begin
            low_ff     <= 1'b0;
            low_sub_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            if (expire)
            begin
                low_ff     <= 1'b1;
                low_sub_ff <= 4'h0;
            end
            else if (low_end)
                low_ff <= 1'b0;
            else if (low_ff && tick)
                low_sub_ff <= low_sub_ff + 4'h1;
        end
    end

    assign line_out = ~low_ff;

    a_filt_load: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (active && !counting_ff && fall) ##1 active
        |-> cnt_ff == $past(filter_value))
        else $error("filter not preloaded");
    a_filt_count: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (active && counting_ff && !rise && cnt_ff != 8'h00) ##1 active
        |-> cnt_ff == $past(cnt_ff) - 8'h01)
        else $error("filter not decrementing");
    a_filt_reload: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (active && counting_ff && rise) ##1 active
        |-> !counting_ff && !low_ff)
        else $error("rising edge did not stop filter");
    a_filt_low: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (active && expire) ##1 active |-> !line_out)
        else $error("expired filter did not drive low");
endmodule : irda_rx_filter

// [logic/uart_line_modes.sv]
// Purpose: serial port with line-driver, smart-card T=1, infrared modes
// Assumes: Avalon-MM slave, 8 data bits, 16 sub-ticks per bit
// Notes: writes need all byte enables; unmapped reads return zero
`timescale 1ns/100ps
module uart_line_modes
    import uart_modes_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rxd,
    output logic             txd,
    output logic             rts,
    output logic             irq
);
    import uart_modes_pkg::*;

    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  ctrl_ff;
    mode_cfg_s   cfg_ff;
    logic [15:0] cd_ff;
    logic [7:0]  filt_ff;
    logic [10:0] ratio_ff;
    logic [7:0]  rxbuf_ff;
    logic [3:0]  sts_ff;
    logic [3:0]  mask_ff;
    logic        irq_ff;
    logic        txd_ff;
    logic        rts_ff;
    logic        rxd_s1_ff;
    logic        rxd_s2_ff;
    logic [15:0] div_ff;
    logic        tick_ff;
    tx_state_e   tx_state_ff;
    tx_state_e   nxt_tx_state;
    logic [3:0]  tx_sub_ff;
    logic [7:0]  tx_cnt_ff;
    logic [7:0]  tx_shift_ff;
    logic        tx_par_ff;
    rx_state_e   rx_state_ff;
    rx_state_e   nxt_rx_state;
    logic [3:0]  rx_sub_ff;
    logic [2:0]  rx_cnt_ff;
    logic [7:0]  rx_shift_ff;
    logic        rx_par_ff;
    logic        filt_line;

    // bus handshake: one wait cycle, then the access completes
    wire bus_req = avs_read | avs_write;
    wire acc     = bus_req & ~wait_ff;
    wire wr_acc  = avs_write & acc & (avs_byteenable == 4'hF);
    wire rd_take = avs_read & wait_ff;
    wire wr_ctrl = wr_acc & (avs_address == ADDR_CTRL);
    wire wr_mode = wr_acc & (avs_address == ADDR_MODE);
    wire wr_div  = wr_acc & (avs_address == ADDR_DIV);
    wire wr_filt = wr_acc & (avs_address == ADDR_FILT);
    wire wr_rat  = wr_acc & (avs_address == ADDR_RATIO);
    wire wr_txd  = wr_acc & (avs_address == ADDR_TXDATA);
    wire wr_sts  = wr_acc & (avs_address == ADDR_STATUS);
    wire wr_mask = wr_acc & (avs_address == ADDR_MASK);

    // mode decode
    wire rs485_mode = cfg_ff.mode == MODE_RS485;
    wire t1_mode    = cfg_ff.mode == MODE_T1;
    wire irda_mode  = cfg_ff.mode == MODE_IRDA;
    wire par_on     = t1_mode | cfg_ff.par_en;
    wire par_odd    = t1_mode ? 1'b0 : cfg_ff.par_odd;
    wire tx_en      = ctrl_ff[CTRL_TXEN];
    wire rx_en      = ctrl_ff[CTRL_RXEN];
    wire all_done   = (tx_state_ff == TX_IDLE) & tx_en;

    // read multiplexer
    wire [31:0] rmux =
        (avs_address == ADDR_CTRL)   ? {30'h0, ctrl_ff} :
        (avs_address == ADDR_MODE)   ? {16'h0, cfg_ff} :
        (avs_address == ADDR_DIV)    ? {16'h0, cd_ff} :
        (avs_address == ADDR_FILT)   ? {24'h0, filt_ff} :
        (avs_address == ADDR_RATIO)  ? {21'h0, ratio_ff} :
        (avs_address == ADDR_RXDATA) ? {24'h0, rxbuf_ff} :
        (avs_address == ADDR_STATUS) ?
            {23'h0, all_done, 4'h0, sts_ff} :
        (avs_address == ADDR_MASK)   ? {28'h0, mask_ff} : 32'h0;

    // bus slave flops
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end
        else if (clk_en)
        begin
            wait_ff <= ~(bus_req & wait_ff);
            if (rd_take) rdata_ff <= rmux;
        end
    end

    // configuration registers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ctrl_ff  <= 2'b00;
            cfg_ff   <= '0;
            cd_ff    <= DIV_RESET;
            filt_ff  <= FILT_RESET;
            ratio_ff <= RATIO_RESET;
            mask_ff  <= 4'h0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl) ctrl_ff <= avs_writedata[1:0];
            if (wr_mode) cfg_ff <= {avs_writedata[15:8], 2'b00,
                                    avs_writedata[5:0]};
            if (wr_div)  cd_ff <= avs_writedata[15:0];
            if (wr_filt) filt_ff <= avs_writedata[7:0];
            if (wr_rat)  ratio_ff <= avs_writedata[10:0];
            if (wr_mask) mask_ff <= avs_writedata[3:0];
        end
    end

    // sub-tick generator; 16-bit divisor spans every infrared rate
    wire div_wrap = ({1'b0, div_ff} + 17'h1) >= {1'b0, cd_ff};
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            div_ff  <= 16'h0;
            tick_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            div_ff  <= div_wrap ? 16'h0 : div_ff + 16'h1;
            tick_ff <= div_wrap & (cd_ff != 16'h0);
        end
    end

    // pin synchroniser
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            rxd_s1_ff <= rxd;
            rxd_s2_ff <= rxd_s1_ff;
        end
    end

    irda_rx_filter u_filter (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .clk_en       (clk_en),
        .active       (irda_mode),
        .line_in      (rxd_s2_ff),
        .filter_value (filt_ff),
        .tick         (tick_ff),
        .line_out     (filt_line)
    );

    // receive path: demodulator switched in for infrared
    wire rx_line = irda_mode ? filt_line : rxd_s2_ff;

    // transmitter state machine
    wire tx_bit_end = tick_ff & (tx_sub_ff == SUB_LAST);
    wire tx_load    = wr_txd & tx_en & (tx_state_ff == TX_IDLE);
    wire tx_last_db = tx_cnt_ff[2:0] == DATA_LAST;
    wire tx_guard_end = tx_cnt_ff == cfg_ff.guard - 8'h01;
    always_comb
    begin
        nxt_tx_state = tx_state_ff;
        case (tx_state_ff)
            TX_IDLE:  if (tx_load) nxt_tx_state = TX_START;
            TX_START: if (tx_bit_end) nxt_tx_state = TX_DATA;
            TX_DATA:
                if (tx_bit_end && tx_last_db)
                    nxt_tx_state = par_on ? TX_PAR : TX_STOP;
            TX_PAR:   if (tx_bit_end) nxt_tx_state = TX_STOP;
            TX_STOP:
                if (tx_bit_end)
                    nxt_tx_state = (cfg_ff.guard != 8'h00) ?
                                   TX_GUARD : TX_IDLE;
            TX_GUARD:
                if (tx_bit_end && tx_guard_end)
                    nxt_tx_state = TX_IDLE;
            default:  nxt_tx_state = TX_IDLE;
        endcase
    end

    // transmitter datapath
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            tx_state_ff <= TX_IDLE;
            tx_sub_ff   <= 4'h0;
            tx_cnt_ff   <= 8'h0;
            tx_shift_ff <= 8'h0;
            tx_par_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_state_ff <= nxt_tx_state;
            if (tx_load)
            begin
                tx_sub_ff   <= 4'h0;
                tx_cnt_ff   <= 8'h0;
                tx_shift_ff <= avs_writedata[7:0];
                tx_par_ff   <= parity_of(avs_writedata[7:0],
                                         par_odd);
            end
            else if (tick_ff && tx_state_ff != TX_IDLE)
                tx_sub_ff <= tx_sub_ff + 4'h1;
            if (tx_bit_end && tx_state_ff == TX_DATA)
            begin
                tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                tx_cnt_ff   <= tx_last_db ? 8'h0 : tx_cnt_ff + 8'h1;
            end
            if (tx_bit_end && tx_state_ff == TX_GUARD)
                tx_cnt_ff <= tx_cnt_ff + 8'h1;
        end
    end

    // line level of the current bit
    wire tx_level = (tx_state_ff == TX_START) ? 1'b0 :
                    (tx_state_ff == TX_DATA)  ? tx_shift_ff[0] :
                    (tx_state_ff == TX_PAR)   ? tx_par_ff : 1'b1;
    // infrared: pulse only in the first 3 sub-ticks of a zero bit
    wire ir_pulse = ~tx_level & (tx_sub_ff < IR_PULSE);

    // pin drivers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            txd_ff <= 1'b1;
            rts_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            txd_ff <= irda_mode ? ir_pulse : tx_level;
            rts_ff <= rs485_mode & ~all_done;
        end
    end

    // receiver state machine
    wire rx_sample = tick_ff & (rx_sub_ff == SUB_LAST);
    wire rx_mid    = tick_ff & (rx_sub_ff == SUB_MID);
    always_comb
    begin
        nxt_rx_state = rx_state_ff;
        case (rx_state_ff)
            RX_IDLE:  if (rx_en && !rx_line) nxt_rx_state = RX_START;
            RX_START:
                if (rx_mid)
                    nxt_rx_state = rx_line ? RX_IDLE : RX_DATA;
            RX_DATA:
                if (rx_sample && rx_cnt_ff == DATA_LAST)
                    nxt_rx_state = par_on ? RX_PAR : RX_STOP;
            RX_PAR:   if (rx_sample) nxt_rx_state = RX_STOP;
            RX_STOP:  if (rx_sample) nxt_rx_state = RX_IDLE;
            default:  nxt_rx_state = RX_IDLE;
        endcase
        if (!rx_en) nxt_rx_state = RX_IDLE;
    end

    // receiver datapath
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rx_state_ff <= RX_IDLE;
            rx_sub_ff   <= 4'h0;
            rx_cnt_ff   <= 3'h0;
            rx_shift_ff <= 8'h0;
            rx_par_ff   <= 1'b0;
            rxbuf_ff    <= 8'h0;
        end
        else if (clk_en)
        begin
            rx_state_ff <= nxt_rx_state;
            if (rx_state_ff == RX_IDLE || rx_mid && rx_state_ff == RX_START)
                rx_sub_ff <= 4'h0;
            else if (tick_ff)
                rx_sub_ff <= rx_sub_ff + 4'h1;
            if (rx_state_ff == RX_START)
                rx_cnt_ff <= 3'h0;
            if (rx_sample && rx_state_ff == RX_DATA)
            begin
                rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
                rx_cnt_ff   <= rx_cnt_ff + 3'h1;
            end
            if (rx_sample && rx_state_ff == RX_PAR)
                rx_par_ff <= rx_line;
            if (rx_sample && rx_state_ff == RX_STOP)
                rxbuf_ff <= rx_shift_ff;
        end
    end

    // events into sticky status
    wire rx_done  = rx_sample & (rx_state_ff == RX_STOP) & rx_en;
    wire parity_error_flag_ev  = rx_done & par_on &
                    (parity_of(rx_shift_ff, par_odd) != rx_par_ff);
    wire [EV_W-1:0] ev;
    assign ev[ST_RXRDY]  = rx_done;
    assign ev[ST_PARITY_ERROR_FLAG]   = parity_error_flag_ev;
    assign ev[ST_FRAME]  = rx_done & ~rx_line;
    assign ev[ST_TXDONE] = (tx_state_ff != TX_IDLE) &
                           (nxt_tx_state == TX_IDLE);
    wire [EV_W-1:0] clr = wr_sts ? avs_writedata[EV_W-1:0] : 4'h0;

    // status, set wins over write-one-clear; interrupt level
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sts_ff <= 4'h0;
            irq_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            sts_ff <= (sts_ff & ~clr) | ev;
            irq_ff <= |(((sts_ff & ~clr) | ev) & mask_ff);
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign txd             = txd_ff;
    assign rts             = rts_ff;
    assign irq             = irq_ff;

    // checks on framing, modulation and line-driver control
    a_stop_single: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (tx_state_ff == TX_STOP && tx_bit_end)
        |=> tx_state_ff inside {TX_IDLE, TX_GUARD})
        else $error("more than one stop bit");
    a_parity_error_flag_flag: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        parity_error_flag_ev |=> sts_ff[ST_PARITY_ERROR_FLAG])
        else $error("parity error not flagged");
    a_irda_path: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        irda_mode |-> rx_line == filt_line)
        else $error("demodulator not in receive path");
    a_pulse_len: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (irda_mode && cd_ff == 16'h0001 && $rose(txd_ff))
        ##1 irda_mode [*3] |-> $past(txd_ff, 2) && $past(txd_ff)
        && !txd_ff)
        else $error("infrared pulse not three sub-ticks");
    a_one_dark: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        ($past(irda_mode) && $past(tx_level)) |-> !txd_ff)
        else $error("pulse sent for a one bit");
    a_rts_busy: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (rs485_mode && !all_done) ##1 rs485_mode |-> rts_ff)
        else $error("line driver off during transmission");
    a_guard_rts: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (rs485_mode && tx_state_ff == TX_GUARD) ##1 rs485_mode
        |-> rts_ff)
        else $error("line driver released in timeguard");
    a_t1_format: assert property (@(posedge core_clk)
        disable iff (!resetn || !clk_en)
        (t1_mode && tx_state_ff == TX_DATA && tx_bit_end && tx_last_db)
        |=> tx_state_ff == TX_PAR)
        else $error("smart-card frame lacks parity");
    c_irda_tx: cover property (@(posedge core_clk)
        irda_mode && $rose(txd_ff));
    c_rs485_guard: cover property (@(posedge core_clk)
        rs485_mode && tx_state_ff == TX_GUARD);
    c_t1_parity_error_flag: cover property (@(posedge core_clk)
        t1_mode && parity_error_flag_ev);
endmodule : uart_line_modes
